// ---- hdl/dw_paging_dev.sv ----
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ns
module dw_paging_dev (
    input wire logic aclk, // system clock
    input wire logic aresetn, // synchronous reset, active low
    dw_ds_if.dev ds, // data-space bus from the core
    output logic [12:0] prog_addr, // program memory read address
    input wire logic [7:0] prog_rdata, // program memory byte for prog_addr, valid in the same cycle, sampled at the next edge
    output logic nv_power_down // store held in low power
);
    import dw_pkg::*;

    // paging registers, deliberately without reset
    logic [6:0] window_q; // window position bits
    logic [4:0] page_q; // page select code
    // control state
    logic standby_q; // store in standby
    logic enable_q; // programming enabled
    logic row_mode_q; // row latch mode
    logic start_q; // row programming launched
    dw_prog_t state_q; // programming sequencer
    logic [15:0] cnt_q; // cycles left in programming
    // row latches
    logic [7:0] row_data_q [0:7]; // latched row bytes
    logic [7:0] row_mask_q; // bytes loaded since row mode
    logic row_valid_q; // row address locked
    logic [3:0] row_addr_q; // page bit and address bits 5..3
    // byte programming target
    logic [6:0] pend_idx_q; // store index being programmed
    logic [7:0] pend_data_q; // byte being programmed
    // memories
    logic [7:0] ram_mem [0:127]; // two extra ram pages
    logic [7:0] nv_mem [0:127]; // two nonvolatile pages
    // read pipeline
    logic s1_valid_q; // access taken last cycle
    logic s1_win_q; // access was a window read
    logic [7:0] s1_data_q; // read byte for non-window reads
    logic [12:0] prog_addr_q; // registered program address
    logic [7:0] rdata_q; // answer byte
    logic ack_q; // answer strobe

    // address decode
    wire take = ds.rd | ds.wr;
    wire in_bank = (ds.addr[7:6] == 2'b00);
    wire in_win = (ds.addr[7:6] == 2'b01);
    wire sel_nv = (page_q == PAGE_NV0) | (page_q == PAGE_NV1);
    wire sel_ram = (page_q == PAGE_RAM1) | (page_q == PAGE_RAM2);
    wire busy = (state_q != ST_IDLE);
    // same low address in every page
    wire [6:0] nv_idx = {page_q == PAGE_NV1, ds.addr[5:0]};
    wire [6:0] ram_idx = {page_q == PAGE_RAM2, ds.addr[5:0]};
    // store usable only selected, awake, idle
    wire nv_ok = in_bank & sel_nv & ~standby_q & ~busy;
    wire nv_wr = ds.wr & nv_ok;
    // writes in row mode load latches
    wire row_hit = ~row_valid_q | (row_addr_q == nv_idx[6:3]);
    wire latch_load = nv_wr & row_mode_q & row_hit;
    // byte programming needs the enable bit
    wire byte_start = nv_wr & ~row_mode_q & enable_q;
    wire ctl_wr = ds.wr & (ds.addr == ADDR_CTL) & ~busy;
    // start needs enable and row mode already set
    wire row_start = ctl_wr & ds.wdata[CTL_ROW_START] & ds.wdata[CTL_ROW_MODE] & enable_q & row_mode_q;
    wire prog_done = busy & (cnt_q == 16'h_0000);
    wire [7:0] ctl_status = {6'b00_0000, busy, 1'b0};

    // read byte for everything but the window
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = DATA_INVALID;
        if (ds.addr == ADDR_CTL) begin
            // only busy is readable; write-only bits read zero
            rd_byte = ctl_status;
        end else if (in_bank & sel_ram) begin
            rd_byte = ram_mem[ram_idx];
        end else if (nv_ok) begin
            rd_byte = nv_mem[nv_idx];
        end
        // window and page registers read as nothing
    end

    // paging register writes, no reset on purpose
    // window and page hold power-up contents
    always_ff @(posedge aclk) begin
        if (ds.wr & (ds.addr == ADDR_WINDOW)) begin
            window_q <= ds.wdata[6:0];
        end
        // page register kept until software writes it
        if (ds.wr & (ds.addr == ADDR_PAGE)) begin
            page_q <= ds.wdata[4:0];
        end
    end

    // read pipeline and window address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_valid_q <= 1'b0;
            s1_win_q <= 1'b0;
            s1_data_q <= 8'h_00;
            prog_addr_q <= 13'h_0000;
            rdata_q <= 8'h_00;
            ack_q <= 1'b0;
        end else begin
            s1_valid_q <= take;
            s1_win_q <= ds.rd & in_win;
            s1_data_q <= rd_byte;
            if (ds.rd & in_win) begin
                // window bits above the 6-bit offset
                prog_addr_q <= {window_q, ds.addr[5:0]};
            end
            ack_q <= s1_valid_q;
            if (s1_valid_q) begin
                // window bytes come from program memory
                rdata_q <= s1_win_q ? prog_rdata : s1_data_q;
            end
        end
    end

    // extra ram pages
    always_ff @(posedge aclk) begin
        if (ds.wr & in_bank & sel_ram) begin
            ram_mem[ram_idx] <= ds.wdata;
        end
    end

    // control register and programming sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            standby_q <= 1'b0;
            enable_q <= 1'b0;
            row_mode_q <= 1'b0;
            start_q <= 1'b0;
            row_valid_q <= 1'b0;
            row_addr_q <= 4'h_0;
            row_mask_q <= 8'h_00;
            state_q <= ST_IDLE;
            cnt_q <= 16'h_0000;
            pend_idx_q <= 7'h_00;
            pend_data_q <= 8'h_00;
        end else begin
            if (ctl_wr) begin
                // standby bit taken from the write
                standby_q <= ds.wdata[CTL_STANDBY];
                enable_q <= ds.wdata[CTL_ENABLE];
                if (!ds.wdata[CTL_ROW_MODE]) begin
                    // leaving row mode drops latches and lock
                    row_mode_q <= 1'b0;
                    row_valid_q <= 1'b0;
                    row_mask_q <= 8'h_00;
                end else if (!row_mode_q) begin
                    // entering row mode clears the latches
                    row_mode_q <= 1'b1;
                    row_valid_q <= 1'b0;
                    row_mask_q <= 8'h_00;
                end
                if (row_start) begin
                    start_q <= 1'b1;
                    state_q <= ST_ROW;
                    cnt_q <= PROG_LAST;
                end
            end else if (latch_load) begin
                // lock row on first load, mark byte
                row_valid_q <= 1'b1;
                row_addr_q <= nv_idx[6:3];
                row_mask_q[ds.addr[2:0]] <= 1'b1;
            end else if (byte_start) begin
                // program the written byte straight away
                state_q <= ST_BYTE;
                cnt_q <= PROG_LAST;
                pend_idx_q <= nv_idx;
                pend_data_q <= ds.wdata;
            end else if (prog_done) begin
                // busy ends after the fixed count
                state_q <= ST_IDLE;
                if (state_q == ST_ROW) begin
                    // row cycle end clears mode and start
                    row_mode_q <= 1'b0;
                    start_q <= 1'b0;
                    row_valid_q <= 1'b0;
                    row_mask_q <= 8'h_00;
                end
            end else if (busy) begin
                // busy held through the whole cycle
                cnt_q <= cnt_q - 16'h_0001;
            end
        end
    end

    // row latches, one per byte of the row
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_row
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    row_data_q[gi] <= 8'h_00;
                end else if (latch_load & (ds.addr[2:0] == 3'(gi))) begin
                    row_data_q[gi] <= ds.wdata;
                end
            end
        end
    endgenerate

    // cells updated when a programming cycle completes
    always_ff @(posedge aclk) begin
        if (prog_done & (state_q == ST_BYTE)) begin
            nv_mem[pend_idx_q] <= pend_data_q;
        end
        // a launched row cycle writes only its loaded bytes
        if (prog_done & start_q) begin
            for (int i = 0; i < 8; i++) begin
                if (row_mask_q[i]) begin
                    nv_mem[{row_addr_q, 3'(i)}] <= row_data_q[i];
                end
            end
        end
    end

    // outputs
    assign ds.rdata = rdata_q;
    assign ds.ack = ack_q;
    assign prog_addr = prog_addr_q;
    assign nv_power_down = standby_q;
endmodule // dw_paging_dev

// ---- hdl/dw_pkg.sv ----
// How it works
// - window area 40h-7Fh reads program memory
// - program address is window bits then offset
// - window register whole-byte write only, unreadable
// - window register has no reset value
// - window moves in 64-byte steps, top unused
// - bank register codes select one page
// - addresses 00h-3Fh go to selected page
// - software sets at most one page bit
// - bank register unreset and never saved
// - software keeps ram image of write-only registers
// - standby bit disables the nonvolatile store
// - no page or standby gives invalid access
// - busy spans programming, accesses then aborted
// - control writes ignored while busy
// - enable bit gates every programming start
// - byte mode programs the written byte directly
// - row is eight bytes sharing upper bits
// - row mode clears latches, writes load them
// - start programs only the loaded row bytes
// - row cycle end clears mode and start
// - start needs enable and row mode set
// - leaving row mode abandons latches and lock
// - control resets to zero, bits 4-5 reserved
package dw_pkg;
    // data-space addresses of the paging and control registers
    localparam logic [7:0] ADDR_WINDOW = 8'h_C9;
    localparam logic [7:0] ADDR_PAGE = 8'h_CB;
    localparam logic [7:0] ADDR_CTL = 8'h_DF;
    // page select codes
    localparam logic [4:0] PAGE_NV0 = 5'h_01;
    localparam logic [4:0] PAGE_NV1 = 5'h_02;
    localparam logic [4:0] PAGE_RAM1 = 5'h_08;
    localparam logic [4:0] PAGE_RAM2 = 5'h_10;
    // control register bit positions
    localparam int CTL_ENABLE = 0;
    localparam int CTL_BUSY = 1;
    localparam int CTL_ROW_MODE = 2;
    localparam int CTL_ROW_START = 3;
    localparam int CTL_STANDBY = 6;
    // value returned for unreadable or invalid accesses
    localparam logic [7:0] DATA_INVALID = 8'h_FF;
    // programming time and its length in 50 MHz cycles
    localparam int CLK_PERIOD_NS = 20;
    localparam int PROG_TIME_NS = 2000;
    localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [15:0] PROG_LAST = 16'(PROG_CYCLES - 1);
    // controller register offsets on the axi4-lite side
    localparam logic [3:0] OFS_CMD = 4'h_0;
    localparam logic [3:0] OFS_STATUS = 4'h_4;
    // command word fields
    localparam int CMD_WDATA_LSB = 8;
    localparam int CMD_WRITE_BIT = 16;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // programming sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_BYTE = 2'b01,
        ST_ROW = 2'b10
    } dw_prog_t;
endpackage

// ---- hdl/dw_ds_if.sv ----
`timescale 1ns/1ns
// data-space bus between processor core and paging block
interface dw_ds_if;
    logic [7:0] addr; // data-space address
    logic [7:0] wdata; // write byte
    logic rd; // one-cycle read strobe
    logic wr; // one-cycle write strobe
    logic [7:0] rdata; // read byte, valid with ack
    logic ack; // one-cycle completion pulse
    modport dev (input addr, input wdata, input rd, input wr, output rdata, output ack);
    modport core (output addr, output wdata, output rd, output wr, input rdata, input ack);
endinterface

// ---- hdl/dw_core_ctrl.sv ----
`timescale 1ns/1ns
module dw_core_ctrl (
    input wire logic aclk, // system clock
    input wire logic aresetn, // synchronous reset, active low
    input wire logic [3:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes, ignored
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [3:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    dw_ds_if.core ds // data-space bus to the paging block
);
    import dw_pkg::*;

    logic aw_got_q; // write address held
    logic [3:0] aw_addr_q; // held write address
    logic w_got_q; // write data held
    logic [31:0] w_data_q; // held write data
    logic bvalid_q; // write response pending
    logic [1:0] bresp_q; // write response code
    logic rvalid_q; // read response pending
    logic [31:0] rdata_q; // read response data
    logic [1:0] rresp_q; // read response code
    logic pend_q; // data-space access outstanding
    logic [7:0] last_rdata_q; // byte returned by the last access, read or write
    logic [7:0] ds_addr_q; // data-space address
    logic [7:0] ds_wdata_q; // data-space write byte
    logic ds_rd_q; // read strobe
    logic ds_wr_q; // write strobe

    // handshake decode
    wire wr_go = aw_got_q & w_got_q & ~bvalid_q;
    wire cmd_hit = (aw_addr_q == OFS_CMD);
    // a command is taken only when no access is outstanding
    wire cmd_ok = wr_go & cmd_hit & ~pend_q;
    wire rd_go = s_axi_arvalid & ~rvalid_q;
    wire [31:0] status_word = {16'h_0000, last_rdata_q, 7'h_00, pend_q};

    // axi write channel and command launch
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q <= 1'b0;
            aw_addr_q <= 4'h_0;
            w_got_q <= 1'b0;
            w_data_q <= 32'h_0000_0000;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_got_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_got_q <= 1'b1;
                w_data_q <= s_axi_wdata;
            end
            if (wr_go) begin
                // both halves present: answer and release
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= cmd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_q & s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // data-space access issue and completion
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pend_q <= 1'b0;
            last_rdata_q <= 8'h_00;
            ds_addr_q <= 8'h_00;
            ds_wdata_q <= 8'h_00;
            ds_rd_q <= 1'b0;
            ds_wr_q <= 1'b0;
        end else begin
            ds_rd_q <= 1'b0;
            ds_wr_q <= 1'b0;
            if (cmd_ok) begin
                // one-cycle strobe with address and byte
                pend_q <= 1'b1;
                ds_addr_q <= w_data_q[7:0];
                ds_wdata_q <= w_data_q[CMD_WDATA_LSB +: 8];
                ds_wr_q <= w_data_q[CMD_WRITE_BIT];
                ds_rd_q <= ~w_data_q[CMD_WRITE_BIT];
            end else if (pend_q & ds.ack) begin
                pend_q <= 1'b0;
                last_rdata_q <= ds.rdata;
            end
        end
    end

    // axi read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h_0000_0000;
            rresp_q <= RESP_OKAY;
        end else if (rd_go) begin
            rvalid_q <= 1'b1;
            if (s_axi_araddr == OFS_STATUS) begin
                rdata_q <= status_word;
                rresp_q <= RESP_OKAY;
            end else if (s_axi_araddr == OFS_CMD) begin
                rdata_q <= {15'h_0000, ds_wr_q, ds_wdata_q, ds_addr_q};
                rresp_q <= RESP_OKAY;
            end else begin
                // unmapped offset
                rdata_q <= 32'h_0000_0000;
                rresp_q <= RESP_SLVERR;
            end
        end else if (rvalid_q & s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // outputs
    assign s_axi_awready = ~aw_got_q & ~bvalid_q;
    assign s_axi_wready = ~w_got_q & ~bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign ds.addr = ds_addr_q;
    assign ds.wdata = ds_wdata_q;
    assign ds.rd = ds_rd_q;
    assign ds.wr = ds_wr_q;
endmodule // dw_core_ctrl

// ---- tb/dw_assertions.sv ----
`timescale 1ns/1ns
// watches the data-space bus between controller and paging block
module dw_assertions
    import dw_pkg::*;
(
    input wire logic aclk, // system clock
    input wire logic aresetn, // sync reset, active low
    input wire logic [7:0] addr, // data-space address
    input wire logic [7:0] wdata, // write byte
    input wire logic rd, // read strobe
    input wire logic wr, // write strobe
    input wire logic [7:0] rdata, // read byte
    input wire logic ack // completion pulse
);
    logic req; // any strobe
    logic [4:0] pg_q; // last page code written, unused top bits dropped
    logic pg_bad; // page code selects nothing
    assign req = rd | wr;
    assign pg_bad = !(pg_q inside {PAGE_NV0, PAGE_NV1, PAGE_RAM1, PAGE_RAM2});
    // shadow of the page register, never reset like the real one
    always_ff @(posedge aclk) begin
        if (wr && addr == ADDR_PAGE) begin
            pg_q <= wdata[4:0];
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_ack_time;
        req |=> !ack ##1 ack ##1 !ack;
    endproperty
    a_ack_time: assert property (p_ack_time) else $error("ack not two cycles after strobe");
    property p_ack_cause;
        ack |-> $past(req, 2);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without strobe");
    property p_one_req;
        req |=> !req [*2];
    endproperty
    a_one_req: assert property (p_one_req) else $error("strobes too close");
    property p_win_unread;
        rd && addr == ADDR_WINDOW |-> ##2 rdata == DATA_INVALID;
    endproperty
    a_win_unread: assert property (p_win_unread) else $error("window register readable");
    property p_page_unread;
        rd && addr == ADDR_PAGE |-> ##2 rdata == DATA_INVALID;
    endproperty
    a_page_unread: assert property (p_page_unread) else $error("page register readable");
    property p_ctl_fmt;
        rd && addr == ADDR_CTL |-> ##2 (rdata & 8'h_FD) == 8'h_00;
    endproperty
    a_ctl_fmt: assert property (p_ctl_fmt) else $error("control read shows write-only bits");
    property p_no_page;
        rd && addr < 8'h_40 && pg_bad |-> ##2 rdata == DATA_INVALID;
    endproperty
    a_no_page: assert property (p_no_page) else $error("read with no page gave data");
    property p_rdata_hold;
        !ack |-> $stable(rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read byte moved between acks");
    // main traffic kinds
    c_window: cover property (rd && addr[7:6] == 2'b01);
    c_ctl_wr: cover property (wr && addr == ADDR_CTL);
    c_no_page: cover property (rd && addr < 8'h_40 && pg_bad);
endmodule // dw_assertions

// ---- tb/tb_top.sv ----
`timescale 1ns/1ns
// both ends joined, driven from the axi side
module tb_top;
    import dw_pkg::*;
    logic aclk = 1'b0; // system clock
    logic aresetn = 1'b0; // sync reset
    logic [3:0] awaddr = 4'h_0, araddr = 4'h_0; // axi addresses
    logic [31:0] wdata = 32'h_0; // axi write data
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid; // slave handshakes
    logic [1:0] bresp, rresp; // responses
    logic [31:0] rdata; // axi read data
    logic [12:0] prog_addr; // program memory address
    logic [7:0] prog_rdata; // program memory byte
    logic nv_power_down; // standby level
    int n_errors = 0, tests_run = 0; // counters
    dw_ds_if ds();
    // free-running clock
    always #10 aclk = ~aclk;
    // program memory: a pattern computed from the address
    function automatic logic [7:0] rom(input logic [12:0] a);
        return a[7:0] ^ a[12:5] ^ 8'h_5A;
    endfunction
    assign prog_rdata = rom(prog_addr);
    dw_paging_dev i_dw_paging_dev (.aclk(aclk), .aresetn(aresetn), .ds(ds), .prog_addr(prog_addr),
        .prog_rdata(prog_rdata), .nv_power_down(nv_power_down));
    dw_core_ctrl i_dw_core_ctrl (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h_F),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ds(ds));
    dw_assertions i_dw_assertions (.aclk(aclk), .aresetn(aresetn), .addr(ds.addr), .wdata(ds.wdata),
        .rd(ds.rd), .wr(ds.wr), .rdata(ds.rdata), .ack(ds.ack));
    // prints counts and verdict, ends the run
    task automatic summarize;
        $display("checks %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // four-state compare of any result
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // a wait ran out of its bound
    task automatic hung;
        n_errors++;
        $display("CHECK FAILED at %0t: wait limit reached", $time);
        summarize();
    endtask
    // axi write: address and data together, held until taken
    task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 50);
        bready <= 1'b0;
        r = bresp;
        if (n >= 50) hung();
    endtask
    // axi read
    task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 50);
        rready <= 1'b0;
        d = rdata;
        r = rresp;
        if (n >= 50) hung();
    endtask
    // one data-space access through the command word, then poll
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        logic [31:0] s;
        logic [1:0] r;
        int n;
        axw(OFS_CMD, {15'h_0, w, d, a}, r);
        chk(32'(r), 32'(RESP_OKAY));
        n = 0;
        do begin
            axr(OFS_STATUS, s, r);
            n++;
        end while (s[0] !== 1'b0 && n < 20);
        if (n >= 20) hung();
        q = s[15:8];
    endtask
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        acc(1'b1, a, d, q);
    endtask
    // read a byte and compare it
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        acc(1'b0, a, 8'h_00, q);
        chk(32'(q), 32'(e));
    endtask
    // poll the busy flag until programming ends
    task automatic idle;
        logic [7:0] q;
        int n;
        n = 0;
        do begin
            acc(1'b0, ADDR_CTL, 8'h_00, q);
            n++;
        end while (q[CTL_BUSY] !== 1'b0 && n < 60);
        if (n >= 60) hung();
    endtask
    // main sequence
    initial begin
        logic [7:0] w, o, win_img;
        logic [31:0] s;
        logic [1:0] r;
        void'($urandom(32'h_f4bc_32ff));
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        // window at extremes and random spots
        for (int i = 0; i < 10; i++) begin
            w = (i == 0) ? 8'h_00 : (i == 1) ? 8'h_FF : 8'($urandom);
            o = (i == 1) ? 8'h_3F : 8'($urandom_range(63));
            // software image updated before the write-only register
            win_img = w;
            put(ADDR_WINDOW, win_img);
            rc(8'h_40 + o, rom({win_img[6:0], o[5:0]}));
            chk(32'(prog_addr), 32'({win_img[6:0], o[5:0]}));
        end
        rc(ADDR_WINDOW, DATA_INVALID);
        rc(ADDR_PAGE, DATA_INVALID);
        $display("test window done");
        // two ram pages at the same low address
        w = 8'($urandom);
        o = 8'($urandom_range(63));
        put(ADDR_PAGE, {3'b0, PAGE_RAM1});
        put(o, w);
        put(ADDR_PAGE, {3'b0, PAGE_RAM2});
        put(o, ~w);
        rc(o, ~w);
        put(ADDR_PAGE, {3'b0, PAGE_RAM1});
        rc(o, w);
        put(ADDR_PAGE, 8'h_00);
        rc(o, DATA_INVALID);
        put(ADDR_PAGE, 8'h_09);
        rc(o, DATA_INVALID);
        $display("test pages done");
        // byte programming, busy window, ignored control write
        put(ADDR_PAGE, {3'b0, PAGE_NV0});
        put(ADDR_CTL, 8'h_01);
        put(8'h_19, 8'h_5A);
        rc(ADDR_CTL, 8'h_02);
        rc(8'h_19, DATA_INVALID);
        put(ADDR_CTL, 8'h_40);
        idle();
        chk(32'(nv_power_down), 32'h_0);
        rc(8'h_19, 8'h_5A);
        put(ADDR_CTL, 8'h_00);
        put(8'h_19, 8'h_11);
        rc(ADDR_CTL, 8'h_00);
        rc(8'h_19, 8'h_5A);
        put(ADDR_CTL, 8'h_40);
        chk(32'(nv_power_down), 32'h_1);
        rc(8'h_19, DATA_INVALID);
        $display("test byte done");
        // row of three bytes, neighbour 19h untouched
        put(ADDR_CTL, 8'h_01);
        put(ADDR_CTL, 8'h_05);
        put(8'h_18, 8'h_A1);
        put(8'h_1A, 8'h_A2);
        put(8'h_1B, 8'h_A3);
        put(ADDR_CTL, 8'h_0D);
        idle();
        rc(8'h_18, 8'h_A1);
        rc(8'h_19, 8'h_5A);
        rc(8'h_1B, 8'h_A3);
        put(8'h_18, 8'h_B4);
        idle();
        rc(8'h_18, 8'h_B4);
        put(ADDR_CTL, 8'h_09);
        rc(ADDR_CTL, 8'h_00);
        put(ADDR_CTL, 8'h_05);
        put(8'h_18, 8'h_C5);
        put(ADDR_CTL, 8'h_01);
        rc(ADDR_CTL, 8'h_00);
        rc(8'h_18, 8'h_B4);
        // second store page at the same low address
        put(ADDR_PAGE, {3'b0, PAGE_NV1});
        put(8'h_19, 8'h_3C);
        idle();
        rc(8'h_19, 8'h_3C);
        put(ADDR_PAGE, {3'b0, PAGE_NV0});
        rc(8'h_19, 8'h_5A);
        $display("test row done");
        // controller offset outside its map
        axr(4'h_8, s, r);
        chk(32'(r), 32'(RESP_SLVERR));
        $display("test axi done");
        summarize();
    end
endmodule // tb_top
